// File: verilog/dev_status_regs.svh
// Offsets, field positions, reset values and codes of the status and checksum registers
`ifndef DEV_STATUS_REGS_SVH
`define DEV_STATUS_REGS_SVH

// Register offsets within a page
`define OFS_PAGE_SELECT        8'h00
`define OFS_DEVICE_STATUS_ONE  8'h7A
`define OFS_WRITE_CHECKSUM     8'h7E

// Page on which the status and checksum registers live
`define PAGE_STATUS            8'h00

// Reset values
`define RST_PAGE_SELECT        8'h00
`define RST_DEVICE_STATUS_ONE  8'h80
`define RST_WRITE_CHECKSUM     8'h00

// Field positions in device_status_one
`define POS_OPERATING_STATE_HI 7
`define POS_OPERATING_STATE_LO 5
`define POS_SYNTH_ON           4
`define POS_MIC_BIAS_ON        3
`define POS_STATUS_RESERVED    2
`define POS_INPUT_FAULT_DOWN   1
`define POS_BIAS_FAULT_DOWN    0

// Operating state codes
`define STATE_CODE_SLEEP       3'h4
`define STATE_CODE_IDLE        3'h6
`define STATE_CODE_ACTIVE      3'h7

// Value of the reserved status bit
`define STATUS_RESERVED_VALUE  1'b0

// Reset value of the read data and of the forwarded address and write data
`define READ_ZERO              8'h00

`endif

// File: verilog/dev_status_pkg.sv
// Types shared by the status and checksum register bank
`default_nettype none
`include "dev_status_regs.svh"

package dev_status_pkg;

  // Operating state codes reported in the status register
  typedef enum logic [2:0]
  {
    OP_SLEEP  = `STATE_CODE_SLEEP,
    OP_IDLE   = `STATE_CODE_IDLE,
    OP_ACTIVE = `STATE_CODE_ACTIVE
  } op_state_t;

  // Layout of device_status_one
  typedef struct packed
  {
    op_state_t operatingStateCode;
    logic      synthesizerOnFlag;
    logic      micBiasOnFlag;
    logic      reservedBit;
    logic      inputFaultShutdownFlag;
    logic      biasFaultTotalShutdownFlag;
  } status_fields_t;

  // Internal device state that the status register reflects
  typedef struct packed
  {
    logic sleepOrShutdown;
    logic anyChannelOn;
    logic synthesizerEnabled;
    logic micBiasEnabled;
  } device_state_t;

  // One register access from the control port decoder
  typedef struct packed
  {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage
`default_nettype wire

// File: verilog/write_checksum_acc.sv
// Running eight-bit checksum of control port writes
`timescale 1ns/1ps
`default_nettype none
`include "dev_status_regs.svh"

module write_checksum_acc
  import dev_status_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       foldStrobe,
  input  wire logic       loadStrobe,
  input  wire logic [7:0] dataByte,
  output logic      [7:0] writeChecksumValue
);

  logic [7:0] next_writeChecksumValue;

  // Load takes priority; otherwise each write byte is added modulo 256
  always_comb
  begin
    next_writeChecksumValue = writeChecksumValue;
    if (loadStrobe)
    begin
      next_writeChecksumValue = dataByte;                         // see RQ9
    end
    else if (foldStrobe)
    begin
      next_writeChecksumValue = 8'(writeChecksumValue + dataByte); // see RQ12
    end
  end

  // Checksum register
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      writeChecksumValue <= `RST_WRITE_CHECKSUM;
    end
    else
    begin
      writeChecksumValue <= next_writeChecksumValue;
    end
  end

endmodule
`default_nettype wire

// File: verilog/device_status_and_write_checksum.sv
// Paged register bank holding device status and the control port write checksum
`timescale 1ns/1ps
`default_nettype none
`include "dev_status_regs.svh"

// Behaviour
// RQ1: Status bits 7 to 5 give the operating state: 4 sleep, 6 active with all channels off, 7 active with one on.
// RQ2: After reset the status register reads 0x80, showing the sleep code.
// RQ3: Status bit 4 is high exactly while the clock synthesizer is enabled.
// RQ4: Status bit 3 is high exactly while the microphone bias supply is enabled.
// RQ5: Status bit 1 is high while any ADC channel is down because of an analog input fault.
// RQ6: Status bit 0 is high only while every ADC channel is down because of a microphone bias fault.
// RQ7: The host treats status bit 2 as reserved; it reads zero and is only written with zero.
// RQ8: Every host write to any other register on any page updates the checksum.
// RQ9: A host write to the checksum register loads that byte instead of folding it in.
// RQ10: The host does not modify offsets that are absent from the register list.
// RQ11: Offset zero selects the page through which all later accesses are routed.
// RQ12: Each written byte is folded into the checksum by modulo-256 addition.
// RQ13: Host writes to the status register are ignored and leave every status bit unchanged.
module device_status_and_write_checksum
  import dev_status_pkg::*;
#(
  parameter int ADC_CHANNELS = 2
)
(
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  input  wire reg_req_t                hostReq,
  output logic                         readValid,
  output logic                   [7:0] readData,
  input  wire device_state_t           deviceState,
  input  wire logic [ADC_CHANNELS-1:0] inputFaultDown,
  input  wire logic [ADC_CHANNELS-1:0] biasFaultDown,
  output logic                   [7:0] currentPage,
  output logic                         fwdWrite,
  output logic                         fwdRead,
  output logic                   [7:0] fwdPage,
  output logic                   [7:0] fwdAddr,
  output logic                   [7:0] fwdWdata,
  input  wire logic              [7:0] fwdRdata,
  output logic                   [7:0] writeChecksumValue,
  output status_fields_t               deviceStatusOne
);

  // Whether an offset on the current page is held by this block
  function automatic logic isLocal(input logic [7:0] page, input logic [7:0] addr);
    logic onStatusPage;
    onStatusPage = (page == `PAGE_STATUS);
    if (addr == `OFS_PAGE_SELECT)
    begin
      isLocal = 1'b1;
    end
    else if (onStatusPage && (addr == `OFS_DEVICE_STATUS_ONE))
    begin
      isLocal = 1'b1;
    end
    else if (onStatusPage && (addr == `OFS_WRITE_CHECKSUM))
    begin
      isLocal = 1'b1;
    end
    else
    begin
      isLocal = 1'b0;
    end
  endfunction

  // Operating state code from the device state
  function automatic op_state_t stateCode(input device_state_t st);
    if (st.sleepOrShutdown)
    begin
      stateCode = OP_SLEEP;
    end
    else if (st.anyChannelOn)
    begin
      stateCode = OP_ACTIVE;
    end
    else
    begin
      stateCode = OP_IDLE;
    end
  endfunction

  logic           localHit;
  logic           checksumHit;
  logic           statusHit;
  logic           pageHit;
  logic           checksumLoad;
  logic           checksumFold;
  logic     [7:0] next_currentPage;
  status_fields_t next_deviceStatusOne;
  logic           next_readValid;
  logic     [7:0] next_readData;
  logic           next_fwdWrite;
  logic     [7:0] next_fwdPage;
  logic     [7:0] next_fwdAddr;
  logic     [7:0] next_fwdWdata;

  // Address decode against the page in force
  always_comb
  begin
    localHit    = isLocal(currentPage, hostReq.addr);           // see RQ11
    pageHit     = (hostReq.addr == `OFS_PAGE_SELECT);
    statusHit   = (currentPage == `PAGE_STATUS) && (hostReq.addr == `OFS_DEVICE_STATUS_ONE);
    checksumHit = (currentPage == `PAGE_STATUS) && (hostReq.addr == `OFS_WRITE_CHECKSUM);
  end

  // Checksum strobes: load on its own offset, fold on every other write
  always_comb
  begin
    checksumLoad = hostReq.write && checksumHit;                // see RQ9
    checksumFold = hostReq.write && !checksumHit;               // see RQ8
  end

  // Page select register
  always_comb
  begin
    next_currentPage = currentPage;
    if (hostReq.write && pageHit)
    begin
      next_currentPage = hostReq.wdata;                         // see RQ11
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      currentPage <= `RST_PAGE_SELECT;
    end
    else
    begin
      currentPage <= next_currentPage;
    end
  end

  // Status register follows device state; host writes never reach it
  always_comb
  begin
    next_deviceStatusOne.operatingStateCode         = stateCode(deviceState);     // see RQ1
    next_deviceStatusOne.synthesizerOnFlag          = deviceState.synthesizerEnabled; // see RQ3
    next_deviceStatusOne.micBiasOnFlag              = deviceState.micBiasEnabled;  // see RQ4
    next_deviceStatusOne.reservedBit                = `STATUS_RESERVED_VALUE;
    next_deviceStatusOne.inputFaultShutdownFlag     = |inputFaultDown;             // see RQ5
    next_deviceStatusOne.biasFaultTotalShutdownFlag = &biasFaultDown;              // see RQ6
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      deviceStatusOne <= status_fields_t'(`RST_DEVICE_STATUS_ONE);  // see RQ2
    end
    else
    begin
      deviceStatusOne <= next_deviceStatusOne;                  // see RQ13
    end
  end

  // Running checksum of host writes
  write_checksum_acc u_checksum
  (
    .mclk               (mclk),
    .resetn             (resetn),
    .foldStrobe         (checksumFold),
    .loadStrobe         (checksumLoad),
    .dataByte           (hostReq.wdata),
    .writeChecksumValue (writeChecksumValue)
  );

  // Reads of other locations go out combinationally to the rest of the map
  always_comb
  begin
    fwdRead = hostReq.read && !localHit;                        // see RQ11
  end

  // Read answer one cycle after the request
  always_comb
  begin
    next_readValid = hostReq.read;
    next_readData  = readData;
    if (hostReq.read)
    begin
      if (pageHit)
      begin
        next_readData = currentPage;
      end
      else if (statusHit)
      begin
        next_readData = deviceStatusOne;
      end
      else if (checksumHit)
      begin
        next_readData = writeChecksumValue;
      end
      else
      begin
        next_readData = fwdRdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      readValid <= 1'b0;
      readData  <= `READ_ZERO;
    end
    else
    begin
      readValid <= next_readValid;
      readData  <= next_readData;
    end
  end

  // Writes to other locations are passed on with the page in force
  always_comb
  begin
    next_fwdWrite = hostReq.write && !localHit;                 // see RQ11
    next_fwdPage  = fwdPage;
    next_fwdAddr  = fwdAddr;
    next_fwdWdata = fwdWdata;
    if (next_fwdWrite || fwdRead)
    begin
      next_fwdPage  = currentPage;
      next_fwdAddr  = hostReq.addr;
      next_fwdWdata = hostReq.wdata;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      fwdWrite <= 1'b0;
      fwdPage  <= `RST_PAGE_SELECT;
      fwdAddr  <= `READ_ZERO;
      fwdWdata <= `READ_ZERO;
    end
    else
    begin
      fwdWrite <= next_fwdWrite;
      fwdPage  <= next_fwdPage;
      fwdAddr  <= next_fwdAddr;
      fwdWdata <= next_fwdWdata;
    end
  end

endmodule
`default_nettype wire

// File: dv/device_status_and_write_checksum_asserts.sv
// Checker for the status and checksum register bank
`timescale 1ns/1ps
`default_nettype none
module device_status_and_write_checksum_asserts
  import dev_status_pkg::*;
#(
  parameter int ADC_CHANNELS = 2
)
(
  input wire logic                    mclk,
  input wire logic                    resetn,
  input wire reg_req_t                hostReq,
  input wire logic                    readValid,
  input wire device_state_t           deviceState,
  input wire logic [ADC_CHANNELS-1:0] inputFaultDown,
  input wire logic [ADC_CHANNELS-1:0] biasFaultDown,
  input wire logic              [7:0] currentPage,
  input wire logic                    fwdWrite,
  input wire logic              [7:0] fwdAddr,
  input wire logic              [7:0] writeChecksumValue,
  input wire status_fields_t          deviceStatusOne
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic isLocal;
  logic ckPlace;
  logic [7:0] expStatus;
  // Decode of locations the bank holds itself
  assign ckPlace = hostReq.addr == 8'h7E && currentPage == 8'h00;
  assign isLocal = hostReq.addr == 8'h00 || ckPlace || (hostReq.addr == 8'h7A && currentPage == 8'h00);
  // Status value the inputs call for
  assign expStatus = {deviceState.sleepOrShutdown ? 3'h4 : (deviceState.anyChannelOn ? 3'h7 : 3'h6),
                      deviceState.synthesizerEnabled, deviceState.micBiasEnabled, 1'b0,
                      |inputFaultDown, &biasFaultDown};
  sequence ckLoad;
    hostReq.write && ckPlace;
  endsequence
  sequence ckFold;
    hostReq.write && !ckPlace;
  endsequence
  a_reset_value: assert property (
    $rose(resetn) |-> deviceStatusOne == 8'h80) else $error("status reset value wrong");
  a_state_code: assert property (
    $past(resetn) |-> deviceStatusOne.operatingStateCode == ($past(deviceState.sleepOrShutdown) ? 3'h4 :
    ($past(deviceState.anyChannelOn) ? 3'h7 : 3'h6))) else $error("state code wrong");
  a_synth_mic: assert property (
    $past(resetn) |-> {deviceStatusOne.synthesizerOnFlag, deviceStatusOne.micBiasOnFlag} ==
    $past({deviceState.synthesizerEnabled, deviceState.micBiasEnabled})) else $error("enable flags wrong");
  a_fault_flags: assert property (
    $past(resetn) |-> deviceStatusOne.inputFaultShutdownFlag == $past(|inputFaultDown) &&
    deviceStatusOne.biasFaultTotalShutdownFlag == $past(&biasFaultDown)) else $error("fault flags wrong");
  a_status_write: assert property (
    hostReq.write && isLocal && hostReq.addr == 8'h7A |=>
    deviceStatusOne == $past(expStatus) && !deviceStatusOne.reservedBit) else $error("status written");
  a_cksum_load: assert property (
    ckLoad |=> writeChecksumValue == $past(hostReq.wdata)) else $error("checksum load wrong");
  a_cksum_fold: assert property (
    ckFold |=> writeChecksumValue == 8'($past(writeChecksumValue) + $past(hostReq.wdata)))
    else $error("checksum fold wrong");
  a_page_select: assert property (
    hostReq.write && hostReq.addr == 8'h00 |=> currentPage == $past(hostReq.wdata)) else $error("page not taken");
  a_fwd_write: assert property (
    hostReq.write && !isLocal |=> fwdWrite && fwdAddr == $past(hostReq.addr)) else $error("write not forwarded");
  a_read_answer: assert property (
    $past(resetn) |-> readValid == $past(hostReq.read)) else $error("read answer timing wrong");
endmodule
bind device_status_and_write_checksum device_status_and_write_checksum_asserts #(.ADC_CHANNELS(ADC_CHANNELS)) chk
(
  .mclk(mclk), .resetn(resetn), .hostReq(hostReq), .readValid(readValid), .deviceState(deviceState),
  .inputFaultDown(inputFaultDown), .biasFaultDown(biasFaultDown), .currentPage(currentPage),
  .fwdWrite(fwdWrite), .fwdAddr(fwdAddr), .writeChecksumValue(writeChecksumValue), .deviceStatusOne(deviceStatusOne)
);
`default_nettype wire

// File: dv/fwd_map_model.sv
// Model of the rest of the paged register map behind the forward port
`timescale 1ns/1ps
`default_nettype none
module fwd_map_model
(
  input  wire logic       mclk,
  input  wire logic       fwdWrite,
  input  wire logic       fwdRead,
  input  wire logic [7:0] fwdPage,
  input  wire logic [7:0] fwdAddr,
  input  wire logic [7:0] fwdWdata,
  input  wire logic [7:0] rdPage,
  input  wire logic [7:0] rdAddr,
  output logic      [7:0] fwdRdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;
  // Stores forwarded writes, remembers the last answer
  always @(posedge mclk)
  begin
    if (fwdWrite)
      mem[{fwdPage, fwdAddr}] <= fwdWdata;
    if (fwdRead)
      last <= fwdRdata;
  end
  // Answers only during a read, else the inverse of the last answer
  assign fwdRdata = fwdRead ? mem[{rdPage, rdAddr}] : ~last;
endmodule
`default_nettype wire

// File: dv/tb_device_status_and_write_checksum.sv
// Testbench for the status and checksum register bank
`timescale 1ns/1ps
`default_nettype none
module tb_device_status_and_write_checksum;
  import dev_status_pkg::*;
  logic           mclk = 1'b0;
  logic           resetn;
  reg_req_t       hostReq;
  device_state_t  deviceState;
  logic     [1:0] inputFaultDown;
  logic     [1:0] biasFaultDown;
  logic           readValid;
  logic           fwdWrite;
  logic           fwdRead;
  logic     [7:0] readData, currentPage, fwdPage, fwdAddr, fwdWdata, fwdRdata, writeChecksumValue;
  status_fields_t deviceStatusOne;
  int             error_cnt = 0;
  int             checks = 0;
  logic     [7:0] ck = 8'h00;
  logic     [7:0] pg = 8'h00;
  // Clock at 40 MHz
  always #12.5 mclk = ~mclk;
  device_status_and_write_checksum #(.ADC_CHANNELS(2)) dut
  (
    .mclk(mclk), .resetn(resetn), .hostReq(hostReq), .readValid(readValid), .readData(readData),
    .deviceState(deviceState), .inputFaultDown(inputFaultDown), .biasFaultDown(biasFaultDown),
    .currentPage(currentPage), .fwdWrite(fwdWrite), .fwdRead(fwdRead), .fwdPage(fwdPage),
    .fwdAddr(fwdAddr), .fwdWdata(fwdWdata), .fwdRdata(fwdRdata),
    .writeChecksumValue(writeChecksumValue), .deviceStatusOne(deviceStatusOne)
  );
  fwd_map_model partner
  (
    .mclk(mclk), .fwdWrite(fwdWrite), .fwdRead(fwdRead), .fwdPage(fwdPage), .fwdAddr(fwdAddr),
    .fwdWdata(fwdWdata), .rdPage(currentPage), .rdAddr(hostReq.addr), .fwdRdata(fwdRdata)
  );
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One write, with the expected checksum and page tracked alongside
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #2;
    hostReq = '{1'b1, 1'b0, a, d};
    @(posedge mclk) #2;
    hostReq = '0;
    ck = (a == 8'h7E && pg == 8'h00) ? d : ck + d;
    if (a == 8'h00)
      pg = d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk) #2;
    hostReq = '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk) #2;
    hostReq = '0;
    check("readValid", {7'h00, readValid}, 8'h01);
    check("readData", readData, exp);
  endtask
  function automatic logic [7:0] expStatus();
    logic [2:0] st;
    st = deviceState.sleepOrShutdown ? 3'h4 : (deviceState.anyChannelOn ? 3'h7 : 3'h6);
    return {st, deviceState.synthesizerEnabled, deviceState.micBiasEnabled, 1'b0, |inputFaultDown, &biasFaultDown};
  endfunction
  task automatic t_reset();
    check("status", deviceStatusOne, 8'h80);
    check("checksum", writeChecksumValue, 8'h00);
    rd(8'h7A, 8'h80);
    rd(8'h7E, 8'h00);
  endtask
  task automatic t_status();
    for (int i = 0; i < 16; i++)
    begin
      deviceState = device_state_t'(i[3:0]);
      inputFaultDown = i[1:0];
      biasFaultDown = i[2:1];
      rd(8'h7A, expStatus());
    end
  endtask
  task automatic t_cksum();
    wr(8'h7E, 8'hF0);
    wr(8'h7A, 8'h4B);
    wr(8'h0D, 8'hA7);
    check("checksum", writeChecksumValue, ck);
    rd(8'h7E, ck);
    check("status", deviceStatusOne, expStatus());
  endtask
  task automatic t_page();
    wr(8'h00, 8'h03);
    wr(8'h7A, 8'h3C);
    wr(8'h7E, 8'h11);
    rd(8'h7A, 8'h3C);
    rd(8'h00, 8'h03);
    check("checksum", writeChecksumValue, ck);
    wr(8'h00, 8'h00);
    rd(8'h7E, ck);
  endtask
  // Reset in mid-run with the device active, a checksum held and a page selected
  task automatic t_midreset();
    deviceState = device_state_t'(4'h7);
    wr(8'h7E, 8'h5A);
    wr(8'h00, 8'h02);
    @(posedge mclk) #2;
    resetn = 1'b0;
    ck = 8'h00;
    pg = 8'h00;
    #1;
    check("status", deviceStatusOne, 8'h80);
    check("checksum", writeChecksumValue, 8'h00);
    check("currentPage", currentPage, 8'h00);
    repeat (3) @(posedge mclk);
    #2 resetn = 1'b1;
    check("status", deviceStatusOne, 8'h80);
    rd(8'h7E, ck);
    rd(8'h7A, expStatus());
  endtask
  task automatic final_report();
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    hostReq = '0;
    deviceState = device_state_t'(4'h8);
    inputFaultDown = 2'h0;
    biasFaultDown = 2'h0;
    resetn = 1'b0;
    repeat (20) @(posedge mclk);
    #2 resetn = 1'b1;
    t_reset();
    t_status();
    t_cksum();
    t_page();
    t_midreset();
    final_report();
  end
  // Watchdog
  initial
  begin
    #50000;
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
